// >>> rtl/qspi_regs_pkg.sv
// shared constants and types for the serial queue register block
package qspi_regs_pkg;
  localparam int DATA_W = 16;
  localparam int RAM_DEPTH = 48;
  localparam int ADDR_W = 6;
  localparam int ENTRY_W = 4;
  localparam logic [5:0] TX_BASE = 6'h00;
  localparam logic [5:0] RX_BASE = 6'h10;
  localparam logic [5:0] CMD_BASE = 6'h20;
  // control/status bit positions
  localparam int B_COL_ERR_EN = 15;
  localparam int B_ABT_ERR_EN = 14;
  localparam int B_LOCKOUT = 12;
  localparam int B_COL_IRQ_EN = 11;
  localparam int B_ABT_IRQ_EN = 10;
  localparam int B_FIN_IRQ_EN = 8;
  localparam int B_COL_FLAG = 3;
  localparam int B_ABT_FLAG = 2;
  localparam int B_FIN_FLAG = 0;
  localparam int B_RUN_EN = 15;
  localparam logic [15:0] IRQ_CTRL_RESET = 16'h0000;
  localparam logic [15:0] IRQ_CTRL_MASK = 16'hDD00;
  localparam logic [14:0] DELAY_RESET = 15'h0000;
  localparam logic [15:0] CMD_BYTE_MASK = 16'hFF00;
  localparam logic [5:0] ADDR_STEP = 6'h01;

  typedef enum logic [1:0] {
    SEL_IRQ = 2'h0,
    SEL_DELAY = 2'h1,
    SEL_ADDR = 2'h2,
    SEL_DATA = 2'h3
  } reg_sel_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RDWAIT = 2'b10
  } bus_state_t;

  typedef struct packed {
    reg_sel_t sel;
    logic write;
    logic [15:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic active;
    logic [3:0] exec_entry;
    logic cmd_done;
    logic at_end;
    logic halt;
    logic queue_done;
  } engine_status_t;

  typedef struct packed {
    logic we;
    logic [5:0] addr;
    logic [15:0] wdata;
  } ram_port_t;
endpackage : qspi_regs_pkg

// >>> rtl/qspi_queue_ram.sv
// dual-port queue ram: cpu port and engine port, registered reads
`timescale 1ns/1ps
module qspi_queue_ram
  import qspi_regs_pkg::*;
#(
  parameter int DEPTH = RAM_DEPTH,
  parameter int AW = ADDR_W,
  parameter int DW = DATA_W
)
(
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic i_cpu_we,
  input wire logic [AW-1:0] i_cpu_addr,
  input wire logic [DW-1:0] i_cpu_wdata,
  output logic [DW-1:0] o_cpu_rdata,
  input wire logic i_eng_we,
  input wire logic [AW-1:0] i_eng_addr,
  input wire logic [DW-1:0] i_eng_wdata,
  output logic [DW-1:0] o_eng_rdata
);
  generate
    if (DEPTH > (1 << AW) || DEPTH < 1)
    begin : g_bad_depth
      $error("queue ram depth does not fit the address width");
    end
  endgenerate

  logic [DW-1:0] mem [DEPTH];

  function automatic logic in_range(input logic [AW-1:0] a);
    in_range = (int'(a) < DEPTH);
  endfunction : in_range

  // cpu write last so it wins a same-address race with the engine
  always_ff @(posedge i_ref_clk)
  begin
    if (i_eng_we && in_range(i_eng_addr))
      mem[i_eng_addr] <= i_eng_wdata;
    if (i_cpu_we && in_range(i_cpu_addr))
      mem[i_cpu_addr] <= i_cpu_wdata;
  end

  always_ff @(posedge i_ref_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      o_cpu_rdata <= '0;
      o_eng_rdata <= '0;
    end
    else
    begin
      o_cpu_rdata <= in_range(i_cpu_addr) ? mem[i_cpu_addr] : '0;
      o_eng_rdata <= in_range(i_eng_addr) ? mem[i_eng_addr] : '0;
    end
  end
endmodule : qspi_queue_ram

// >>> rtl/qspi_irq_and_ram_access.sv
// interrupt/error register, run enable and indirect queue ram access
// Behaviour
// - data-port write to executing entry during a transfer is a collision.
// - with collision error enable set, colliding write ends in access error.
// - with abort error enable set, clearing run enable mid-transfer errors.
// - abort lock-out stops software clearing run enable; engine still clears.
// - three enable bits gate collision, abort and finished interrupts.
// - collision flag sets on any write to the executing entry.
// - abort flag sets when software, not the engine, clears run enable.
// - finished flag sets on end-of-queue command done, or done after halt.
// - in wrap mode finished sets each time end-of-queue command completes.
// - writing one clears a flag; writing zero leaves it.
// - ram holds 48 words: 16 transmit, 16 receive, 16 command bytes.
// - data-port write stores at address pointer then increments it.
// - data-port read returns entry, increments pointer, one wait state.
// - address pointer does not wrap at a section end.
// - run enable starts execution; engine clears it when transfer completes.
// - halt stops execution after the current command finishes.
`timescale 1ns/1ps
module qspi_irq_and_ram_access
  import qspi_regs_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic i_req,
  input wire reg_req_t i_req_data,
  output logic o_ack,
  output logic o_err,
  output logic [DATA_W-1:0] o_rdata,
  input wire engine_status_t i_eng,
  input wire ram_port_t i_eng_ram,
  output logic [DATA_W-1:0] o_eng_rdata,
  output logic o_run_enable,
  output logic [14:0] o_delay_fields,
  output logic o_irq
);
  bus_state_t state_reg;
  logic [15:0] ctrl_reg;
  logic [2:0] flag_reg;
  logic run_en_reg;
  logic [14:0] delay_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic [DATA_W-1:0] cpu_rdata;

  logic take;
  logic wr_data;
  logic rd_data;
  logic wr_delay;
  logic wr_irq;
  logic collision;
  logic col_err;
  logic abt_try;
  logic abt_err;
  logic sw_clear;
  logic cpu_we;
  logic [DATA_W-1:0] cpu_wdata;
  logic col_set;
  logic fin_set;
  logic [2:0] flag_next;
  logic [15:0] reg_view;

  function automatic logic is_cmd(input logic [ADDR_W-1:0] a);
    is_cmd = (a >= CMD_BASE);
  endfunction : is_cmd

  function automatic logic [ENTRY_W-1:0] entry_of(input logic [ADDR_W-1:0] a);
    entry_of = a[ENTRY_W-1:0];
  endfunction : entry_of

  assign take = i_req && (state_reg == ST_IDLE);
  assign wr_data = take && i_req_data.write && (i_req_data.sel == SEL_DATA);
  assign rd_data = take && !i_req_data.write && (i_req_data.sel == SEL_DATA);
  assign wr_delay = take && i_req_data.write && (i_req_data.sel == SEL_DELAY);
  assign wr_irq = take && i_req_data.write && (i_req_data.sel == SEL_IRQ);

  // entry index matches in any section: transmit, receive and command
  // words of the executing entry are all in use by the engine
  assign collision = wr_data && run_en_reg && i_eng.active
    && (int'(addr_reg) < RAM_DEPTH)
    && (entry_of(addr_reg) == i_eng.exec_entry);
  assign col_err = collision && ctrl_reg[B_COL_ERR_EN];
  assign col_set = collision;

  assign abt_try = wr_delay && !i_req_data.wdata[B_RUN_EN] && run_en_reg;
  assign abt_err = abt_try && i_eng.active && ctrl_reg[B_ABT_ERR_EN];
  assign sw_clear = abt_try && !abt_err && !ctrl_reg[B_LOCKOUT];

  // finished covers end of queue, wrap passes and halt stops alike
  assign fin_set = i_eng.cmd_done && (i_eng.at_end || i_eng.halt);

  // command section keeps only the upper byte
  assign cpu_wdata = is_cmd(addr_reg) ? (i_req_data.wdata & CMD_BYTE_MASK)
    : i_req_data.wdata;
  assign cpu_we = wr_data && !col_err;

  always_comb
  begin
    flag_next = flag_reg;
    if (wr_irq)
    begin
      // write-one-to-clear first, so a same-cycle set below wins
      if (i_req_data.wdata[B_COL_FLAG])
        flag_next[2] = 1'b0;
      if (i_req_data.wdata[B_ABT_FLAG])
        flag_next[1] = 1'b0;
      if (i_req_data.wdata[B_FIN_FLAG])
        flag_next[0] = 1'b0;
    end
    if (col_set)
      flag_next[2] = 1'b1;
    if (sw_clear)
      flag_next[1] = 1'b1;
    if (fin_set)
      flag_next[0] = 1'b1;
  end

  always_comb
  begin
    reg_view = '0;
    unique case (i_req_data.sel)
      SEL_IRQ:
      begin
        reg_view = ctrl_reg;
        reg_view[B_COL_FLAG] = flag_reg[2];
        reg_view[B_ABT_FLAG] = flag_reg[1];
        reg_view[B_FIN_FLAG] = flag_reg[0];
      end
      SEL_DELAY:
        reg_view = {run_en_reg, delay_reg};
      SEL_ADDR:
        reg_view = {{(16 - ADDR_W){1'b0}}, addr_reg};
      SEL_DATA:
        reg_view = '0;
    endcase
  end

  qspi_queue_ram #(
    .DEPTH(RAM_DEPTH),
    .AW(ADDR_W),
    .DW(DATA_W)
  ) u_ram (
    .i_ref_clk(i_ref_clk),
    .i_sys_rst(i_sys_rst),
    .i_cpu_we(cpu_we),
    .i_cpu_addr(addr_reg),
    .i_cpu_wdata(cpu_wdata),
    .o_cpu_rdata(cpu_rdata),
    .i_eng_we(i_eng_ram.we),
    .i_eng_addr(i_eng_ram.addr),
    .i_eng_wdata(i_eng_ram.wdata),
    .o_eng_rdata(o_eng_rdata)
  );

  // bus sequencing: data-port read spends one extra cycle in the ram
  always_ff @(posedge i_ref_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      state_reg <= ST_IDLE;
    else
    begin
      unique case (state_reg)
        ST_IDLE:
          state_reg <= rd_data ? ST_RDWAIT : ST_IDLE;
        ST_RDWAIT:
          state_reg <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      o_ack <= 1'b0;
      o_err <= 1'b0;
      o_rdata <= '0;
    end
    else
    begin
      o_ack <= 1'b0;
      o_err <= 1'b0;
      if (state_reg == ST_RDWAIT)
      begin
        o_ack <= 1'b1;
        o_rdata <= cpu_rdata;
      end
      else if (take && (col_err || abt_err))
        o_err <= 1'b1;
      else if (take && !rd_data)
      begin
        o_ack <= 1'b1;
        o_rdata <= i_req_data.write ? '0 : reg_view;
      end
    end
  end

  // pointer free-runs past 47 and through 63; no section wrap
  always_ff @(posedge i_ref_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      addr_reg <= '0;
    else if (take && i_req_data.write && (i_req_data.sel == SEL_ADDR))
      addr_reg <= i_req_data.wdata[ADDR_W-1:0];
    else if (cpu_we || rd_data)
      addr_reg <= addr_reg + ADDR_STEP;
  end

  always_ff @(posedge i_ref_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      ctrl_reg <= IRQ_CTRL_RESET;
    else if (wr_irq)
      ctrl_reg <= i_req_data.wdata & IRQ_CTRL_MASK;
  end

  always_ff @(posedge i_ref_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      flag_reg <= '0;
    else
      flag_reg <= flag_next;
  end

  // engine completion beats a software set in the same cycle
  always_ff @(posedge i_ref_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      run_en_reg <= 1'b0;
    else if (i_eng.queue_done)
      run_en_reg <= 1'b0;
    else if (wr_delay && i_req_data.wdata[B_RUN_EN])
      run_en_reg <= 1'b1;
    else if (sw_clear)
      run_en_reg <= 1'b0;
  end

  always_ff @(posedge i_ref_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      delay_reg <= DELAY_RESET;
    else if (wr_delay && !abt_err)
      delay_reg <= i_req_data.wdata[14:0];
  end

  always_ff @(posedge i_ref_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      o_run_enable <= 1'b0;
      o_delay_fields <= DELAY_RESET;
      o_irq <= 1'b0;
    end
    else
    begin
      o_run_enable <= run_en_reg;
      o_delay_fields <= delay_reg;
      o_irq <= (flag_reg[2] && ctrl_reg[B_COL_IRQ_EN])
        || (flag_reg[1] && ctrl_reg[B_ABT_IRQ_EN])
        || (flag_reg[0] && ctrl_reg[B_FIN_IRQ_EN]);
    end
  end
endmodule : qspi_irq_and_ram_access

// >>> verif/qspi_irq_and_ram_access_asserts.sv
// port assertions for the queue register block
`timescale 1ns/1ps
module qspi_irq_and_ram_access_asserts
  import qspi_regs_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic i_req,
  input wire reg_req_t i_req_data,
  input wire logic o_ack,
  input wire logic o_err,
  input wire logic [DATA_W-1:0] o_rdata,
  input wire engine_status_t i_eng,
  input wire logic o_run_enable,
  input wire logic [14:0] o_delay_fields,
  input wire logic o_irq
);
  logic wait_reg;
  logic tk, wr, rd, dw;
  assign tk = i_req && !wait_reg;
  assign wr = tk && i_req_data.write;
  assign rd = tk && !i_req_data.write && i_req_data.sel == SEL_DATA;
  assign dw = wr && i_req_data.sel == SEL_DELAY;
  // the wait cycle of a data-port read refuses any request
  always_ff @(posedge i_ref_clk or posedge i_sys_rst)
    if (i_sys_rst)
      wait_reg <= 1'b0;
    else
      wait_reg <= rd;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);
  one_answer_a:
    assert property (tk && !rd |=> o_ack ^ o_err) else $error("no single answer");
  read_wait_a:
    assert property (rd |=> !o_ack && !o_err ##1 o_ack) else $error("read wait wrong");
  stray_answer_a:
    assert property (o_ack || o_err |-> $past(tk && !rd) || $past(rd, 2))
      else $error("stray answer");
  err_cause_a:
    assert property (o_err |-> $past(wr && i_req_data.sel inside {SEL_DATA, SEL_DELAY}))
      else $error("bad error cause");
  irq_gate_a:
    assert property (wr && i_req_data.sel == SEL_IRQ && !(|(i_req_data.wdata & 16'h0D00))
      |-> ##2 !o_irq) else $error("irq not gated");
  run_rise_a:
    assert property ($rose(o_run_enable) |-> $past(dw && i_req_data.wdata[15], 2))
      else $error("run set without write");
  run_fall_a:
    assert property ($fell(o_run_enable) |-> $past(i_eng.queue_done, 2)
      || $past(dw && !i_req_data.wdata[15], 2)) else $error("run cleared without cause");
  write_zero_a:
    assert property (wr ##1 o_ack |-> o_rdata == 16'h0000) else $error("write data not 0");
  delay_upd_a:
    assert property (dw ##1 o_ack |=> o_delay_fields == $past(i_req_data.wdata[14:0], 2))
      else $error("delay not stored");
  cover property (o_err);
  cover property (rd ##2 o_ack);
  cover property ($fell(o_run_enable));
endmodule : qspi_irq_and_ram_access_asserts
bind qspi_irq_and_ram_access qspi_irq_and_ram_access_asserts chk (.*);

// >>> verif/qspi_cpu_model.sv
// cpu bus master model for the queue register block
`timescale 1ns/1ps
module qspi_cpu_model
  import qspi_regs_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_ack,
  input wire logic i_err,
  input wire logic [DATA_W-1:0] i_rdata,
  output logic o_req,
  output reg_req_t o_req_data
);
  initial
  begin
    o_req = 1'b0;
    o_req_data = '0;
  end
  // a missing answer comes back as an unknown error bit
  task automatic xfer(input reg_sel_t s, input logic w, input logic [15:0] d,
    output logic [15:0] q, output logic e);
    int n;
    n = 0;
    @(posedge i_ref_clk);
    o_req <= 1'b1;
    o_req_data <= '{sel: s, write: w, wdata: d};
    @(posedge i_ref_clk);
    o_req <= 1'b0;
    do
      @(negedge i_ref_clk);
    while (i_ack !== 1'b1 && i_err !== 1'b1 && ++n < 4);
    q = i_rdata;
    e = (i_ack | i_err) ? i_err : 1'bx;
  endtask : xfer
endmodule : qspi_cpu_model

// >>> verif/testbench.sv
// self-checking bench for the queue register block
`timescale 1ns/1ps
module testbench;
  import qspi_regs_pkg::*;
  logic i_ref_clk, i_sys_rst, i_req, o_ack, o_err, o_run_enable, o_irq, e;
  reg_req_t i_req_data;
  engine_status_t eng;
  ram_port_t eram;
  logic [15:0] o_rdata, o_eng_rdata, q, lf;
  logic [14:0] o_delay_fields;
  int errors, checked, cyc, ctrl, flg, run, ptr, dly, mem[64];
  qspi_irq_and_ram_access dut (.i_ref_clk, .i_sys_rst, .i_req, .i_req_data, .o_ack,
    .o_err, .o_rdata, .i_eng(eng), .i_eng_ram(eram), .o_eng_rdata, .o_run_enable,
    .o_delay_fields, .o_irq);
  qspi_cpu_model cpu (.i_ref_clk, .i_ack(o_ack), .i_err(o_err), .i_rdata(o_rdata),
    .o_req(i_req), .o_req_data(i_req_data));
  initial
  begin
    i_ref_clk = 1'b0;
    forever #25 i_ref_clk = ~i_ref_clk;
  end
  always @(posedge i_ref_clk)
    if (++cyc > 5000)
    begin
      errors++;
      conclude();
    end
  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : lfsr
  task automatic chk(input logic [15:0] g, input logic [15:0] x);
    checked++;
    if (g !== x)
    begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, g, x);
    end
  endtask : chk
  task automatic conclude();
    $display("checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : conclude
  task automatic outs();
    repeat (2) @(negedge i_ref_clk);
    chk(16'(o_irq), 16'(ctrl[11] & flg[3] | ctrl[10] & flg[2] | ctrl[8] & flg[0]));
    chk(16'(o_run_enable), 16'(run));
    chk(16'(o_delay_fields), 16'(dly));
  endtask : outs
  task automatic op(input reg_sel_t s, input logic w, input logic [15:0] d);
    logic [15:0] x;
    logic xe;
    int p;
    cpu.xfer(s, w, d, q, e);
    x = 16'h0000;
    xe = 1'b0;
    p = ptr;
    case (s)
      SEL_IRQ:
        if (w)
        begin
          ctrl = d & 16'hDD00;
          flg &= ~(d & 16'h000D);
        end
        else
          x = 16'(ctrl | flg);
      SEL_DELAY:
        if (!w)
          x = 16'(run * 32768 + dly);
        else if (!d[15] && run && eng.active && ctrl[14])
          xe = 1'b1;
        else
        begin
          dly = d[14:0];
          if (d[15])
            run = 1;
          else if (run && !ctrl[12])
          begin
            run = 0;
            flg |= 4;
          end
        end
      SEL_ADDR:
        ptr = d[5:0];
      default:
      begin
        if (w && run && eng.active && p < 48 && p[3:0] == eng.exec_entry)
        begin
          flg |= 8;
          xe = ctrl[15];
        end
        if (!xe)
        begin
          if (!w)
            x = p < 48 ? 16'(mem[p]) : 16'h0000;
          else if (p < 48)
            mem[p] = p < 32 ? d : d & 16'hFF00;
          ptr = (p + 1) % 64;
        end
      end
    endcase
    chk(16'(e), 16'(xe));
    if (!xe)
      chk(q, x);
    outs();
  endtask : op
  task automatic wr(input reg_sel_t s, input logic [15:0] d);
    op(s, 1'b1, d);
  endtask : wr
  task automatic rd(input reg_sel_t s);
    op(s, 1'b0, 16'h0000);
  endtask : rd
  task automatic pulse(input logic at, input logic hl, input logic qd);
    @(posedge i_ref_clk);
    eng.cmd_done <= 1'b1;
    eng.at_end <= at;
    eng.halt <= hl;
    eng.queue_done <= qd;
    @(posedge i_ref_clk);
    eng.cmd_done <= 1'b0;
    eng.queue_done <= 1'b0;
    if (at || hl)
      flg |= 1;
    if (qd)
      run = 0;
    outs();
  endtask : pulse
  initial
  begin
    i_sys_rst = 1'b1;
    eng = '0;
    eram = '0;
    lf = 16'h0061;
    repeat (2) @(posedge i_ref_clk);
    i_sys_rst <= 1'b0;
    rd(SEL_IRQ);
    rd(SEL_DELAY);
    wr(SEL_IRQ, 16'hFFFF);
    rd(SEL_IRQ);
    $display("test reset done");
    wr(SEL_ADDR, 16'h000E);
    repeat (36)
    begin
      lf = lfsr(lf);
      wr(SEL_DATA, lf);
    end
    wr(SEL_ADDR, 16'h000E);
    repeat (36) rd(SEL_DATA);
    @(posedge i_ref_clk);
    eram <= '{1'b1, 6'h11, lf};
    mem[17] = lf;
    @(posedge i_ref_clk);
    eram.we <= 1'b0;
    // the write edge still latches the old word, so read one edge later
    @(posedge i_ref_clk);
    @(negedge i_ref_clk);
    chk(o_eng_rdata, lf);
    wr(SEL_ADDR, 16'h0010);
    repeat (2) rd(SEL_DATA);
    $display("test ram done");
    wr(SEL_IRQ, 16'h0D0D);
    pulse(1'b1, 1'b0, 1'b0);
    wr(SEL_IRQ, 16'h0D00);
    pulse(1'b0, 1'b1, 1'b0);
    wr(SEL_IRQ, 16'h0D01);
    pulse(1'b0, 1'b0, 1'b0);
    pulse(1'b1, 1'b0, 1'b0);
    rd(SEL_IRQ);
    wr(SEL_IRQ, 16'h0000);
    $display("test flags done");
    wr(SEL_DELAY, 16'h8123);
    pulse(1'b0, 1'b0, 1'b1);
    wr(SEL_DELAY, 16'h8000);
    @(posedge i_ref_clk);
    eng.active <= 1'b1;
    eng.exec_entry <= 4'h3;
    wr(SEL_DELAY, 16'h0000);
    wr(SEL_IRQ, 16'h1000);
    wr(SEL_DELAY, 16'h8000);
    wr(SEL_DELAY, 16'h0000);
    wr(SEL_IRQ, 16'h5000);
    wr(SEL_DELAY, 16'h0000);
    rd(SEL_IRQ);
    $display("test abort done");
    wr(SEL_IRQ, 16'h000D);
    wr(SEL_ADDR, 16'h0013);
    wr(SEL_DATA, 16'h1357);
    wr(SEL_IRQ, 16'h8000);
    wr(SEL_ADDR, 16'h0022);
    repeat (2) wr(SEL_DATA, 16'hABCD);
    wr(SEL_ADDR, 16'h0022);
    repeat (2) rd(SEL_DATA);
    wr(SEL_ADDR, 16'h0013);
    rd(SEL_DATA);
    rd(SEL_IRQ);
    $display("test collision done");
    conclude();
  end
endmodule : testbench
